/* hw/dpb_pkg.sv */
// Purpose: Shared constants and types for the acquisition bus interface
// Assumes: 16-bit shared bus words, 32-bit AHB-Lite register bus
// Notes:   Register offsets are byte addresses, one aligned word each
package dpb_pkg;
  // ****************************************************************
  // Widths and sizes
  // ****************************************************************
  localparam int DW         = 16;
  localparam int ERRQ_DEPTH = 8;
  localparam int ERRQ_AW    = 3;
  localparam int SYNC_W     = 58;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFS_VECTOR = 8'h00;
  localparam logic [7:0] OFS_RDATA  = 8'h04;
  localparam logic [7:0] OFS_WDATA  = 8'h08;
  localparam logic [7:0] OFS_ERRQ   = 8'h0c;
  localparam logic [7:0] OFS_ERRL   = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // ****************************************************************
  // Vectors, addresses and reserved words
  // ****************************************************************
  localparam logic [7:0]  VEC_ERR_READ  = 8'h60;
  localparam logic [7:0]  VEC_SNAPSHOT_TRIGGER      = 8'h63;
  localparam logic [7:0]  VEC_ERR_CLEAR = 8'h67;
  localparam logic [15:0] ADDR_IFC      = 16'hffff;
  localparam logic [15:0] NULL_WORD     = 16'h0000;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [7:0]  RST_MODULE_ID = 8'h80;

  // ****************************************************************
  // State machines
  // ****************************************************************
  typedef enum logic [2:0] {
    M_IDLE, M_ADDR, M_RD_DS, M_RD_REQ, M_WR_REQ, M_WR_DS, M_DONE, M_CLEAR
  } dpb_mstate_e;

  typedef enum logic [2:0] {
    S_IDLE, S_INTR, S_ACK, S_RD_WAIT, S_RELEASE
  } dpb_sstate_e;
endpackage : dpb_pkg

/* hw/dpb_top.sv */
// Purpose: Master bus interface and slave bus interface of the shared
//          acquisition bus, with the slave processor view on AHB-Lite
// Assumes: Host and shared bus pins asynchronous to CLK_SYS_I; zero wait AHB slave
// Notes:   Summary of operation follows
//
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/100ps
module dpb_top #(
  parameter logic [7:0] MODULE_ID = dpb_pkg::RST_MODULE_ID
) (
  // Clock and reset
  input  wire logic                   CLK_SYS_I,
  input  wire logic                   SRST_I,
  // AHB-Lite slave
  input  wire logic                   HSEL_I,
  input  wire logic [31:0]            HADDR_I,
  input  wire logic [1:0]             HTRANS_I,
  input  wire logic                   HWRITE_I,
  input  wire logic [2:0]             HSIZE_I,
  input  wire logic [31:0]            HWDATA_I,
  input  wire logic                   HREADY_I,
  output      logic [31:0]            HRDATA_O,
  output      logic                   HREADYOUT_O,
  output      logic                   HRESP_O,
  // Host parallel interface
  input  wire logic                   HOST_TRANSACTION_FLAG_I,
  input  wire logic                   HOST_TRIGGER_FLAG_I,
  input  wire logic [dpb_pkg::DW-1:0] HOST_OUTPUT_BUFFER_I,
  input  wire logic                   HOST_OUTPUT_READY_PULSE_I,
  input  wire logic                   HOST_INPUT_TAKEN_PULSE_I,
  output      logic [dpb_pkg::DW-1:0] HOST_INPUT_LATCH_O,
  output      logic                   HOST_REQUEST_A_O,
  output      logic                   HOST_ERROR_REQUEST_O,
  // Master end of the shared bus
  input  wire logic [dpb_pkg::DW-1:0] MB_DATA_I,
  output      logic [dpb_pkg::DW-1:0] MB_DATA_O,
  output      logic                   MB_DATA_OE_O,
  output      logic                   ADDR_STROBE_O,
  output      logic                   DATA_STROBE_O,
  input  wire logic                   MB_ACK_I,
  input  wire logic                   MB_ERROR_I,
  output      logic                   SNAPSHOT_TRIGGER_O,
  output      logic                   INTERFACE_CLEAR_O,
  // Slave end of the shared bus
  input  wire logic [dpb_pkg::DW-1:0] SB_DATA_I,
  output      logic [dpb_pkg::DW-1:0] SB_DATA_O,
  output      logic                   SB_DATA_OE_O,
  input  wire logic                   SB_ADDR_STROBE_I,
  input  wire logic                   SB_DATA_STROBE_I,
  input  wire logic                   SB_TRIGGER_I,
  input  wire logic                   SB_INTERFACE_CLEAR_I,
  output      logic                   SB_ACK_O,
  output      logic                   SB_ACK_OE_O,
  output      logic                   SB_ERROR_O,
  output      logic                   SB_ERROR_OE_O,
  // Slave processor side
  output      logic                   IRQ5_N_O,
  output      logic                   SYSRESET_N_O,
  output      logic                   MODULE_SELECT_N_O
);
  import dpb_pkg::*;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [SYNC_W-1:0] sync_raw;
  logic              edge_reg;

  assign sync_raw = {HOST_TRANSACTION_FLAG_I, HOST_TRIGGER_FLAG_I,
                     HOST_OUTPUT_READY_PULSE_I, HOST_INPUT_TAKEN_PULSE_I,
                     MB_ACK_I, MB_ERROR_I, SB_ADDR_STROBE_I,
                     SB_DATA_STROBE_I, SB_TRIGGER_I, SB_INTERFACE_CLEAR_I,
                     HOST_OUTPUT_BUFFER_I, MB_DATA_I, SB_DATA_I};

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      edge_reg  <= '0;
    end else begin
      sync1_reg <= sync_raw;
      sync2_reg <= sync1_reg;
      edge_reg  <= sync2_reg[55];
    end
  end

  wire          flag_s   = sync2_reg[57];
  wire          tflag_s  = sync2_reg[56];
  wire          ready_s  = sync2_reg[55];
  wire          taken_s  = sync2_reg[54];
  wire          mack_s   = sync2_reg[53];
  wire          merr_s   = sync2_reg[52];
  wire          sas_s    = sync2_reg[51];
  wire          sds_s    = sync2_reg[50];
  wire          strig_s  = sync2_reg[49];
  wire          sifc_s   = sync2_reg[48];
  wire [DW-1:0] hbuf_s   = sync2_reg[47:32];
  wire [DW-1:0] mdat_s   = sync2_reg[31:16];
  wire [DW-1:0] sdat_s   = sync2_reg[15:0];
  // Host pulses are far longer than two clocks, so act on rising edges
  wire          ready_rise = ready_s & ~edge_reg;
  // Taken pulse keeps its own delay flop, cleared with the master state
  logic         taken_prev_reg;
  wire          taken_edge = taken_s & ~taken_prev_reg;

  // ****************************************************************
  // Master bus interface
  // ****************************************************************
  dpb_mstate_e  m_state_reg, m_state_next;
  logic         as_reg, as_next, ds_reg, ds_next, host_request_a_reg, host_request_a_next;
  logic         moe_reg, moe_next, ifc_reg, ifc_next;
  logic [DW-1:0] mdata_reg, mdata_next, inlatch_reg, inlatch_next;

  always_comb begin
    m_state_next = m_state_reg;
    as_next      = as_reg;
    ds_next      = ds_reg;
    host_request_a_next    = host_request_a_reg;
    moe_next     = moe_reg;
    ifc_next     = ifc_reg;
    mdata_next   = mdata_reg;
    inlatch_next = inlatch_reg;
    case (m_state_reg)
      M_IDLE: begin
        if (flag_s && ready_rise && hbuf_s == ADDR_IFC) begin
          ifc_next     = 1'b1;
          m_state_next = M_CLEAR;
        end else if (flag_s && ready_rise) begin
          mdata_next   = hbuf_s;
          moe_next     = 1'b1;
          as_next      = 1'b1;
          m_state_next = M_ADDR;
        end
      end
      M_ADDR: begin
        if (!flag_s) begin
          // Host gave up waiting: withdraw the address
          as_next      = 1'b0;
          moe_next     = 1'b0;
          m_state_next = M_IDLE;
        end else if (mack_s && !mdata_reg[0]) begin
          as_next      = 1'b0;
          ds_next      = 1'b1;
          moe_next     = 1'b0;
          m_state_next = M_RD_DS;
        end else if (mack_s) begin
          as_next      = 1'b0;
          moe_next     = 1'b0;
          host_request_a_next    = 1'b1;
          m_state_next = M_WR_REQ;
        end
      end
      M_RD_DS: begin
        if (!mack_s) begin
          ds_next      = 1'b0;
          inlatch_next = mdat_s;
          host_request_a_next    = 1'b1;
          m_state_next = M_RD_REQ;
        end
      end
      M_RD_REQ: begin
        if (taken_edge) begin
          host_request_a_next    = 1'b0;
          m_state_next = M_DONE;
        end
      end
      M_WR_REQ: begin
        if (ready_rise) begin
          mdata_next   = hbuf_s;
          moe_next     = 1'b1;
          ds_next      = 1'b1;
          host_request_a_next    = 1'b0;
          m_state_next = M_WR_DS;
        end
      end
      M_WR_DS: begin
        if (!mack_s) begin
          ds_next      = 1'b0;
          moe_next     = 1'b0;
          m_state_next = M_DONE;
        end
      end
      M_DONE: begin
        if (!flag_s) m_state_next = M_IDLE;
      end
      M_CLEAR: begin
        if (!flag_s) begin
          ifc_next     = 1'b0;
          m_state_next = M_IDLE;
        end
      end
      default: m_state_next = M_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      m_state_reg    <= M_IDLE;
      {as_reg, ds_reg, host_request_a_reg, moe_reg, ifc_reg} <= '0;
      mdata_reg      <= '0;
      inlatch_reg    <= '0;
      taken_prev_reg <= 1'b0;
    end else begin
      m_state_reg    <= m_state_next;
      {as_reg, ds_reg, host_request_a_reg, moe_reg, ifc_reg} <=
        {as_next, ds_next, host_request_a_next, moe_next, ifc_next};
      mdata_reg      <= mdata_next;
      inlatch_reg    <= inlatch_next;
      taken_prev_reg <= taken_s;
    end
  end

  // ****************************************************************
  // Slave bus interface
  // ****************************************************************
  dpb_sstate_e   s_state_reg, s_state_next;
  logic [7:0]    vec_reg, vec_next;
  logic          rd_reg, rd_next, snapshot_trigger_reg, snapshot_trigger_next, lock_reg, lock_next;
  logic          ack_reg, ack_next, soe_reg, soe_next, sel_reg, sel_next;
  logic [DW-1:0] sdata_reg, sdata_next, wdata_reg, wdata_next;
  logic          wvalid_reg, errl_reg, strig_prev_reg;
  logic [DW-1:0] errq_mem [ERRQ_DEPTH];
  logic [ERRQ_AW-1:0] errq_wp_reg, errq_rp_reg;
  logic [ERRQ_AW:0]   errq_cnt_reg;
  logic          wr_take, err_clear, errq_pop;

  wire match      = sas_s && sdat_s[15:8] == MODULE_ID;
  wire snapshot_trigger_rise  = strig_s & ~strig_prev_reg;
  wire errq_empty = errq_cnt_reg == '0;
  wire [DW-1:0] errq_head = errq_empty ? NULL_WORD : errq_mem[errq_rp_reg];
  logic vec_ack, rdata_wr, errq_push, errl_set, wdata_rd;

  always_comb begin
    s_state_next = s_state_reg;
    vec_next     = vec_reg;
    rd_next      = rd_reg;
    snapshot_trigger_next    = snapshot_trigger_reg;
    lock_next    = lock_reg;
    ack_next     = ack_reg;
    soe_next     = soe_reg;
    sel_next     = sel_reg;
    sdata_next   = sdata_reg;
    wdata_next   = wdata_reg;
    wr_take      = 1'b0;
    err_clear    = 1'b0;
    errq_pop     = 1'b0;
    case (s_state_reg)
      S_IDLE: begin
        if (snapshot_trigger_rise && !lock_reg) begin
          vec_next     = VEC_SNAPSHOT_TRIGGER;
          snapshot_trigger_next    = 1'b1;
          lock_next    = 1'b1;
          s_state_next = S_INTR;
        end else if (match && !lock_reg) begin
          vec_next     = sdat_s[7:0];
          rd_next      = ~sdat_s[0];
          sel_next     = 1'b1;
          lock_next    = 1'b1;
          s_state_next = S_INTR;
        end
      end
      S_INTR: begin
        if (vec_ack && snapshot_trigger_reg) begin
          snapshot_trigger_next    = 1'b0;
          lock_next    = 1'b0;
          s_state_next = S_IDLE;
        end else if (vec_ack) begin
          ack_next     = 1'b1;
          s_state_next = S_ACK;
        end
      end
      S_ACK: begin
        if (sds_s && rd_reg && vec_reg == VEC_ERR_READ) begin
          sdata_next   = errq_head;
          errq_pop     = ~errq_empty;
          soe_next     = 1'b1;
          ack_next     = 1'b0;
          s_state_next = S_RELEASE;
        end else if (sds_s && rd_reg) begin
          s_state_next = S_RD_WAIT;
        end else if (sds_s) begin
          wdata_next   = sdat_s;
          wr_take      = 1'b1;
          err_clear    = vec_reg == VEC_ERR_CLEAR && sdat_s == NULL_WORD;
          ack_next     = 1'b0;
          s_state_next = S_RELEASE;
        end
      end
      S_RD_WAIT: begin
        if (rdata_wr) begin
          sdata_next   = HWDATA_I[DW-1:0];
          soe_next     = 1'b1;
          ack_next     = 1'b0;
          s_state_next = S_RELEASE;
        end
      end
      S_RELEASE: begin
        if (!sds_s) begin
          soe_next     = 1'b0;
          sel_next     = 1'b0;
          lock_next    = 1'b0;
          s_state_next = S_IDLE;
        end
      end
      default: s_state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      s_state_reg    <= S_IDLE;
      vec_reg        <= '0;
      {rd_reg, snapshot_trigger_reg, lock_reg, ack_reg, soe_reg, sel_reg} <= '0;
      sdata_reg      <= '0;
      wdata_reg      <= '0;
      strig_prev_reg <= 1'b0;
    end else begin
      s_state_reg    <= s_state_next;
      vec_reg        <= vec_next;
      {rd_reg, snapshot_trigger_reg, lock_reg, ack_reg, soe_reg, sel_reg} <=
        {rd_next, snapshot_trigger_next, lock_next, ack_next, soe_next, sel_next};
      sdata_reg      <= sdata_next;
      wdata_reg      <= wdata_next;
      strig_prev_reg <= strig_s;
    end
  end

  // Error string queue and latch; software set wins over a bus clear
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      errq_wp_reg  <= '0;
      errq_rp_reg  <= '0;
      errq_cnt_reg <= '0;
      errl_reg     <= 1'b0;
      wvalid_reg   <= 1'b0;
    end else begin
      if (errq_push) errq_wp_reg <= errq_wp_reg + 1'b1;
      if (errq_pop)  errq_rp_reg <= errq_rp_reg + 1'b1;
      errq_cnt_reg <= errq_cnt_reg + {3'h0, errq_push} - {3'h0, errq_pop};
      errl_reg     <= errl_set | (errl_reg & ~err_clear);
      wvalid_reg   <= wr_take | (wvalid_reg & ~wdata_rd);
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (errq_push) errq_mem[errq_wp_reg] <= HWDATA_I[DW-1:0];
  end

  // ****************************************************************
  // AHB-Lite register slave
  // ****************************************************************
  logic       wpend_reg;
  logic [7:0] waddr_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] rd_word;

  wire        a_valid = HSEL_I & HREADY_I & HTRANS_I[1];
  wire        a_read  = a_valid & ~HWRITE_I;
  wire [7:0]  a_ofs   = {HADDR_I[7:2], 2'h0};
  wire        errq_full = errq_cnt_reg == 4'(ERRQ_DEPTH);

  // Reading the vector is the processor's interrupt acknowledge
  assign vec_ack   = a_read && a_ofs == OFS_VECTOR &&
                     s_state_reg == S_INTR;
  assign wdata_rd  = a_read && a_ofs == OFS_WDATA;
  assign rdata_wr  = wpend_reg && waddr_reg == OFS_RDATA;
  assign errq_push = wpend_reg && waddr_reg == OFS_ERRQ && !errq_full;
  assign errl_set  = wpend_reg && waddr_reg == OFS_ERRL && HWDATA_I[0];

  always_comb begin
    case (a_ofs)
      OFS_VECTOR: rd_word = {24'h0, vec_reg};
      OFS_WDATA:  rd_word = {16'h0, wdata_reg};
      OFS_ERRL:   rd_word = {31'h0, errl_reg};
      OFS_STATUS: rd_word = {16'h0, 2'h0, wvalid_reg, lock_reg,
                             errq_cnt_reg, 2'h0, s_state_reg,
                             m_state_reg};
      default:    rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      wpend_reg  <= 1'b0;
      waddr_reg  <= '0;
      hrdata_reg <= '0;
    end else begin
      wpend_reg  <= a_valid & HWRITE_I;
      waddr_reg  <= a_ofs;
      if (a_read) hrdata_reg <= rd_word;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign HRDATA_O             = hrdata_reg;
  assign HREADYOUT_O          = 1'b1;
  assign HRESP_O              = 1'b0;
  assign HOST_INPUT_LATCH_O   = inlatch_reg;
  assign HOST_REQUEST_A_O     = host_request_a_reg;
  assign HOST_ERROR_REQUEST_O = merr_s;
  assign MB_DATA_O            = mdata_reg;
  assign MB_DATA_OE_O         = moe_reg;
  assign ADDR_STROBE_O        = as_reg;
  assign DATA_STROBE_O        = ds_reg;
  assign SNAPSHOT_TRIGGER_O   = tflag_s;
  assign INTERFACE_CLEAR_O    = ifc_reg;
  assign SB_DATA_O            = sdata_reg;
  assign SB_DATA_OE_O         = soe_reg;
  assign SB_ACK_O             = ack_reg;
  assign SB_ACK_OE_O          = ack_reg;
  assign SB_ERROR_O           = errl_reg;
  assign SB_ERROR_OE_O        = errl_reg;
  assign IRQ5_N_O             = ~(s_state_reg == S_INTR);
  assign SYSRESET_N_O         = ~sifc_s;
  assign MODULE_SELECT_N_O    = ~sel_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SRST_I);

  sequence s_rd_ack;
    m_state_reg == M_ADDR && flag_s && mack_s && !mdata_reg[0];
  endsequence
  sequence s_wr_ack;
    m_state_reg == M_ADDR && flag_s && mack_s && mdata_reg[0];
  endsequence

  a_addr_drive: assert property (
    (m_state_reg == M_IDLE && flag_s && ready_rise && hbuf_s != ADDR_IFC)
    |=> as_reg && moe_reg && mdata_reg == $past(hbuf_s))
    else $error("address not driven on ready pulse");
  a_rd_strobes: assert property (s_rd_ack |=> !as_reg && ds_reg)
    else $error("read strobes wrong after ack");
  a_rd_latch: assert property (
    (m_state_reg == M_RD_DS && !mack_s)
    |=> !ds_reg && host_request_a_reg && inlatch_reg == $past(mdat_s))
    else $error("read data not latched");
  a_host_request_a_clear: assert property (
    (m_state_reg == M_RD_REQ && taken_edge) |=> !host_request_a_reg)
    else $error("request A not cleared after read");
  a_wr_request: assert property (s_wr_ack |=> !as_reg && host_request_a_reg)
    else $error("write request not raised");
  a_wr_data: assert property (
    (m_state_reg == M_WR_REQ && ready_rise)
    |=> ds_reg && !host_request_a_reg && moe_reg && MB_DATA_O == $past(hbuf_s))
    else $error("write data phase wrong");
  a_wr_end: assert property (
    (m_state_reg == M_WR_DS && !mack_s) |=> !ds_reg && !moe_reg)
    else $error("data strobe held after ack fell");
  a_idle_rx: assert property (
    s_state_reg == S_IDLE |-> !SB_DATA_OE_O && !SB_ACK_OE_O)
    else $error("idle slave drives the bus");
  a_irq_match: assert property (
    (s_state_reg == S_IDLE && match && !lock_reg && !snapshot_trigger_rise)
    |=> !IRQ5_N_O && vec_reg == $past(sdat_s[7:0]) && !MODULE_SELECT_N_O)
    else $error("match did not raise interrupt");
  a_snapshot_trigger_vec: assert property (
    (s_state_reg == S_IDLE && snapshot_trigger_rise && !lock_reg)
    |=> vec_reg == VEC_SNAPSHOT_TRIGGER && !SB_DATA_OE_O && MODULE_SELECT_N_O)
    else $error("trigger vector wrong");
  a_sys_reset: assert property (sifc_s |-> !SYSRESET_N_O)
    else $error("system reset not driven");
  a_err_hold: assert property (
    (errl_reg && !err_clear) |=> errl_reg)
    else $error("error latch dropped without clear");
  a_ifc_hold: assert property (
    (m_state_reg == M_CLEAR && flag_s) |=> INTERFACE_CLEAR_O)
    else $error("interface clear dropped early");
endmodule // dpb_top

/* test/dpb_link.sv */
// Purpose: Shared bus wiring, ack pulldown, wired-OR error line
// Assumes: Released data line floats with no pull resistor
// Notes:   A floating line shows the inverse of its last value
`timescale 1ns/100ps
module dpb_link (
  input  wire logic        clk_i,
  input  wire logic [15:0] md_i,
  input  wire logic        moe_i,
  input  wire logic [15:0] sd_i,
  input  wire logic        soe_i,
  input  wire logic        ack_i,
  input  wire logic        aoe_i,
  input  wire logic        err_i,
  input  wire logic        eoe_i,
  output      logic [15:0] bus_o,
  output      logic        ack_o,
  output      logic        err_o
);
  logic [15:0] last_reg = 16'h0000;
  always_ff @(posedge clk_i) last_reg <= bus_o;
  assign bus_o = moe_i ? md_i : soe_i ? sd_i : ~last_reg;
  assign ack_o = ack_i & aoe_i;
  assign err_o = err_i & eoe_i;
endmodule // dpb_link

/* test/dpb_top_tb.sv */
// Purpose: Self-checking bench for the acquisition bus interface
// Assumes: Slave end looped back to master end through dpb_link
// Notes:   Drivers queue expected words, a watcher compares them
`timescale 1ns/100ps
module dpb_top_tb;
  import dpb_pkg::*;
  logic        clk = 0, rst = 1, hw = 0, fl = 0, tg = 0, rd = 0, tk = 0;
  logic [1:0]  ht = 2'h0;
  logic [31:0] ha = 32'h0, hd = 32'h0, hr, r, cd = 32'h0, q[$];
  logic [15:0] ob = 16'h0, lat, mdo, sdo, bus, w;
  logic        ho, rqa, erq, moe, as, ds, sn, interface_clear, soe, sa, sao, se, seo;
  logic        irq_n, srst_n, msel_n, ack, err, cv = 0;
  int          error_cnt = 0, check_count = 0, seed = 11;
  always #10 clk = ~clk;
  dpb_top i_dpb_top (.CLK_SYS_I(clk), .SRST_I(rst), .HSEL_I(1'b1),
    .HADDR_I(ha), .HTRANS_I(ht), .HWRITE_I(hw), .HSIZE_I(3'h2),
    .HWDATA_I(hd), .HREADY_I(ho), .HRDATA_O(hr), .HREADYOUT_O(ho),
    .HRESP_O(), .HOST_TRANSACTION_FLAG_I(fl), .HOST_TRIGGER_FLAG_I(tg),
    .HOST_OUTPUT_BUFFER_I(ob), .HOST_OUTPUT_READY_PULSE_I(rd),
    .HOST_INPUT_TAKEN_PULSE_I(tk), .HOST_INPUT_LATCH_O(lat),
    .HOST_REQUEST_A_O(rqa), .HOST_ERROR_REQUEST_O(erq), .MB_DATA_I(bus),
    .MB_DATA_O(mdo), .MB_DATA_OE_O(moe), .ADDR_STROBE_O(as),
    .DATA_STROBE_O(ds), .MB_ACK_I(ack), .MB_ERROR_I(err),
    .SNAPSHOT_TRIGGER_O(sn), .INTERFACE_CLEAR_O(interface_clear), .SB_DATA_I(bus),
    .SB_DATA_O(sdo), .SB_DATA_OE_O(soe), .SB_ADDR_STROBE_I(as),
    .SB_DATA_STROBE_I(ds), .SB_TRIGGER_I(sn), .SB_INTERFACE_CLEAR_I(interface_clear),
    .SB_ACK_O(sa), .SB_ACK_OE_O(sao), .SB_ERROR_O(se), .SB_ERROR_OE_O(seo),
    .IRQ5_N_O(irq_n), .SYSRESET_N_O(srst_n), .MODULE_SELECT_N_O(msel_n));
  dpb_link i_dpb_link (.clk_i(clk), .md_i(mdo), .moe_i(moe), .sd_i(sdo),
    .soe_i(soe), .ack_i(sa), .aoe_i(sao), .err_i(se), .eoe_i(seo),
    .bus_o(bus), .ack_o(ack), .err_o(err));
  always @(posedge clk) begin
    if (cv) begin
      check_count++;
      if (cd !== q[0]) begin
        error_cnt++;
        $display("MISMATCH %0t got %h exp %h", $time, cd, q[0]);
      end
      void'(q.pop_front());
    end
  end
  task automatic chk(input logic [31:0] g, e);
    q.push_back(e);
    cd <= g;
    cv <= 1;
    @(posedge clk);
    cv <= 0;
    @(posedge clk);
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    ht <= HTRANS_NONSEQ;
    ha <= {24'h0, a};
    hw <= wr;
    do @(posedge clk); while (ho !== 1'b1);
    ht <= 2'h0;
    hd <= d;
    do @(posedge clk); while (ho !== 1'b1);
    r = hr;
  endtask
  localparam int W_IRQ = 0, W_REQ = 1, W_DS = 2, W_ERR = 3, W_IFC = 4;
  function automatic logic sig(input int k);
    case (k)
      W_IRQ:   return irq_n;
      W_REQ:   return rqa;
      W_DS:    return ds;
      W_ERR:   return erq;
      default: return interface_clear;
    endcase
  endfunction
  task automatic wt(input int k, input logic v);
    int n;
    n = 0;
    while (sig(k) !== v && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (sig(k) !== v) begin
      error_cnt++;
      $display("MISMATCH %0t wait ran out", $time);
    end
  endtask
  // A 360 ns host pulse is 18 cycles at 50 MHz; t picks taken over ready
  task automatic pulse(input bit t);
    @(posedge clk);
    if (t) tk <= 1;
    else rd <= 1;
    repeat (18) @(posedge clk);
    if (t) tk <= 0;
    else rd <= 0;
  endtask
  task automatic xfer(input logic [15:0] a, d, e);
    int n;
    n = 0;
    fl <= 1;
    ob <= a;
    pulse(0);
    wt(W_IRQ, 0);
    chk({31'h0, msel_n}, 32'h0);
    ahb(0, OFS_VECTOR, 32'h0);
    chk(r, {24'h0, a[7:0]});
    if (!a[0]) begin
      if (a[7:0] != VEC_ERR_READ) begin
        // Read data is only taken once the slave has seen the data strobe
        do begin
          ahb(0, OFS_STATUS, 32'h0);
          n++;
        end while (r[5:3] != S_RD_WAIT && n < 100);
        ahb(1, OFS_RDATA, {16'h0, d});
      end
      wt(W_REQ, 1);
      chk({16'h0, lat}, {16'h0, e});
      pulse(1);
      wt(W_REQ, 0);
    end else begin
      wt(W_REQ, 1);
      ob <= d;
      pulse(0);
      wt(W_REQ, 0);
      wt(W_DS, 0);
      ahb(0, OFS_WDATA, 32'h0);
      chk(r, {16'h0, e});
    end
    fl <= 0;
    repeat (8) @(posedge clk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #400us;
    error_cnt++;
    $display("MISMATCH %0t watchdog expired", $time);
    summarize();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    w = 16'($random(seed));
    xfer(16'h8070, w, w);
    w = 16'($random(seed));
    xfer(16'h8071, w, w);
    $display("fetch and pass done");
    ahb(1, OFS_ERRQ, 32'hcd01);
    ahb(1, OFS_ERRQ, 32'h0005);
    ahb(1, OFS_ERRL, 32'h1);
    wt(W_ERR, 1);
    xfer(16'h8060, NULL_WORD, 16'hcd01);
    xfer(16'h8060, NULL_WORD, 16'h0005);
    xfer(16'h8060, NULL_WORD, NULL_WORD);
    chk({31'h0, erq}, 32'h1);
    xfer(16'h8067, NULL_WORD, NULL_WORD);
    wt(W_ERR, 0);
    $display("error string done");
    fl <= 1;
    ob <= ADDR_IFC;
    pulse(0);
    wt(W_IFC, 1);
    chk({31'h0, srst_n}, 32'h0);
    fl <= 0;
    wt(W_IFC, 0);
    tg <= 1;
    wt(W_IRQ, 0);
    ahb(0, OFS_VECTOR, 32'h0);
    chk(r, {24'h0, VEC_SNAPSHOT_TRIGGER});
    tg <= 0;
    fl <= 1;
    ob <= 16'h8170;
    pulse(0);
    repeat (200) @(posedge clk);
    chk({31'h0, rqa}, 32'h0);
    fl <= 0;
    // Dropping the flag must withdraw the unanswered address
    repeat (6) @(posedge clk);
    chk({31'h0, as}, 32'h0);
    $display("clear, trigger and no-slave done");
    summarize();
  end
endmodule // dpb_top_tb
